// file: hw/vcd_chain.v
// Summary of operation
// - dead band compensation only in open loop and internal feedback, per coil
// - dead band step applied once input leaves zero, A positive, B negative
// - coil A setting for positive inputs, coil B setting for negative
// - open loop: dead band is a milliampere step added to coil current
// - internal feedback: dead band is percent offset with input sign
// - each coil current capped by its own milliampere limit
// - full scale drive yields exactly the limit current while dither amplitude is zero
// - dither wave of set amplitude and frequency added to coil current
// - one pid in internal or external, two cascaded in combined
// - pid output is p times error plus i integral plus d derivative
// - first order output delay weighted by time constant t
// - external sensor type selectable: 0-10 v, 0-20 ma, 4-20 ma
// - sensor type defaults to 0-10 v
// - feedback polarity inverts or passes; off means sensor disconnected
// - command below threshold suppressed, larger passed unchanged
`timescale 1ns/1ps
`include "vcd_defines.vh"

module vcd_pid
(
  // clock and reset
  input  wire                   i_clk,
  input  wire                   i_rstn,
  input  wire                   i_tick,
  // error and gains
  input  wire signed [15:0]     i_err,
  input  wire        [15:0]     i_p,
  input  wire        [15:0]     i_i,
  input  wire        [15:0]     i_d,
  input  wire        [15:0]     i_t,
  // output
  output reg  signed [15:0]     o_u
);
  reg  signed [31:0] integ_r;
  reg  signed [15:0] err_prev_r;
  wire signed [47:0] p_term;
  wire signed [47:0] i_term;
  wire signed [47:0] d_term;
  wire signed [47:0] raw;
  wire signed [31:0] i_nxt;
  wire signed [15:0] raw_sat;
  wire signed [47:0] lag;
  wire signed [15:0] u_nxt;

  // integral clamps at +-100 % of scaled range to avoid windup
  assign i_nxt  = integ_r + {{16{i_err[15]}}, i_err};
  assign p_term = $signed({1'b0, i_p}) * i_err;
  assign i_term = ($signed({1'b0, i_i}) * integ_r) >>> `VCD_W;
  assign d_term = $signed({1'b0, i_d}) * (i_err - err_prev_r);
  assign raw    = (p_term + i_term + d_term) >>> `VCD_FRAC;
  assign raw_sat = (raw > `VCD_FULL) ? `VCD_FULL :
                   (raw < `VCD_NFULL) ? `VCD_NFULL : raw[15:0];
  // t is smoothing weight: 0 passes, larger slows the output
  assign lag    = ($signed({1'b0, i_t}) * (o_u - raw_sat)) >>> `VCD_W;
  assign u_nxt  = raw_sat + lag[15:0];

  always @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      integ_r    <= 32'h0;
      err_prev_r <= 16'h0;
      o_u        <= 16'h0;
    end
    else if (i_tick)
    begin
      if (i_nxt > 32'sh3fffffff)
        integ_r <= 32'sh3fffffff;
      else if (i_nxt < -32'sh3fffffff)
        integ_r <= -32'sh3fffffff;
      else
        integ_r <= i_nxt;
      err_prev_r <= i_err;
      o_u        <= u_nxt;
    end
  end
endmodule // vcd_pid

module vcd_chain
(
  // clock and reset
  input  wire                   i_clk,
  input  wire                   i_rstn,
  // configuration
  input  wire [1:0]             i_cfg,
  input  wire [15:0]            i_threshold,
  input  wire [15:0]            i_db_a,
  input  wire [15:0]            i_db_b,
  input  wire [12:0]            i_lim_a,
  input  wire [12:0]            i_lim_b,
  input  wire [12:0]            i_dith_amp,
  input  wire [23:0]            i_dith_inc,
  input  wire [1:0]             i_sens_type,
  input  wire                   i_sens_type_set,
  input  wire [1:0]             i_fb_pol,
  // controller gains, inner then outer
  input  wire [15:0]            i_p_in,
  input  wire [15:0]            i_i_in,
  input  wire [15:0]            i_d_in,
  input  wire [15:0]            i_t_in,
  input  wire [15:0]            i_p_ex,
  input  wire [15:0]            i_i_ex,
  input  wire [15:0]            i_d_ex,
  input  wire [15:0]            i_t_ex,
  // signals
  input  wire signed [15:0]     i_cmd,
  input  wire signed [15:0]     i_fb_int,
  input  wire [11:0]            i_fb_ext_raw,
  // outputs
  output reg  [12:0]            o_cur_a,
  output reg  [12:0]            o_cur_b,
  output reg  [1:0]             o_sens_type,
  output wire                   o_tick
);
  reg  [11:0]        tick_cnt_r;
  reg  [1:0]         sens_r;
  reg  [23:0]        phase_r;
  wire               tick;
  wire signed [15:0] cmd_th;
  wire               db_en;
  wire signed [15:0] db_pct;
  wire signed [16:0] cmd_db;
  wire signed [15:0] cmd_sat;
  reg  signed [15:0] ext_fb;
  wire signed [15:0] ext_pol;
  wire signed [16:0] err_ex;
  wire signed [16:0] err_in;
  wire signed [15:0] err_ex_s;
  wire signed [15:0] err_in_s;
  wire signed [15:0] u_ex;
  wire signed [15:0] u_in;
  reg  signed [15:0] drive;
  wire [15:0]        mag;
  wire [28:0]        base_a;
  wire [28:0]        base_b;
  wire [13:0]        ol_a;
  wire [13:0]        ol_b;
  wire signed [14:0] dith;
  wire [20:0]        dith_prod;
  wire signed [15:0] tot_a;
  wire signed [15:0] tot_b;

  function signed [15:0] sat17;
    input signed [16:0] v;
    begin
      if (v > `VCD_FULL)
        sat17 = `VCD_FULL;
      else if (v < `VCD_NFULL)
        sat17 = `VCD_NFULL;
      else
        sat17 = v[15:0];
    end
  endfunction

  function [12:0] clip;
    input signed [15:0] v;
    input [12:0] lim;
    begin
      if (v < 16'sh0)
        clip = 13'h0;
      else if (v[14:0] > {2'h0, lim})
        clip = lim;
      else
        clip = v[12:0];
    end
  endfunction

  // sample tick
  assign tick   = (tick_cnt_r == `VCD_SAMPLE_CYC);
  assign o_tick = tick;
  always @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      tick_cnt_r <= 12'h0;
    else if (tick)
      tick_cnt_r <= 12'h0;
    else
      tick_cnt_r <= tick_cnt_r + 12'h1;
  end

  // sensor type held, resets to 0-10 v
  always @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      sens_r <= `VCD_SENS_V10;
    else if (i_sens_type_set)
      sens_r <= i_sens_type;
  end
  always @*
  begin
    o_sens_type = sens_r;
  end

  // threshold then dead band
  assign cmd_th = ((i_cmd < 16'sh0 ? -i_cmd : i_cmd) < $signed({1'b0, i_threshold[14:0]})) ?
                  16'sh0 : i_cmd;
  assign db_en  = (i_cfg == `VCD_CFG_INT);
  assign db_pct = (cmd_th > 16'sh0) ? $signed(i_db_a) :
                  (cmd_th < 16'sh0) ? -$signed(i_db_b) : 16'sh0;
  assign cmd_db = db_en ? ({cmd_th[15], cmd_th} + {db_pct[15], db_pct}) : {cmd_th[15], cmd_th};
  assign cmd_sat = sat17(cmd_db);

  // external sensor scaling; raw 0..fff spans 0-10 v or 0-20 ma, raw 333..fff spans 4-20 ma
  always @*
  begin
    case (sens_r)
      `VCD_SENS_I420:
        ext_fb = (i_fb_ext_raw < `VCD_ADC_4MA) ? 16'sh0 :
                 $signed({4'h0, i_fb_ext_raw - `VCD_ADC_4MA}) * 16'sh5;  // 1.25x span, approx 4
      default:
        ext_fb = $signed({2'h0, i_fb_ext_raw, 2'h0});
    endcase
  end
  // off behaves as an unplugged sensor: reads zero
  assign ext_pol = (i_fb_pol == `VCD_POL_POS) ? ext_fb :
                   (i_fb_pol == `VCD_POL_NEG) ? -ext_fb : 16'sh0;

  assign err_ex   = {cmd_sat[15], cmd_sat} - {ext_pol[15], ext_pol};
  assign err_ex_s = sat17(err_ex);
  // cascade: outer output is inner setpoint in combined mode
  assign err_in   = (i_cfg == `VCD_CFG_COMB) ? ({u_ex[15], u_ex} - {i_fb_int[15], i_fb_int}) :
                    ({cmd_sat[15], cmd_sat} - {i_fb_int[15], i_fb_int});
  assign err_in_s = sat17(err_in);

  vcd_pid u_pid_ex
  (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .i_tick (tick),
    .i_err  (err_ex_s),
    .i_p    (i_p_ex),
    .i_i    (i_i_ex),
    .i_d    (i_d_ex),
    .i_t    (i_t_ex),
    .o_u    (u_ex)
  );
  vcd_pid u_pid_in
  (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .i_tick (tick),
    .i_err  (err_in_s),
    .i_p    (i_p_in),
    .i_i    (i_i_in),
    .i_d    (i_d_in),
    .i_t    (i_t_in),
    .o_u    (u_in)
  );

  always @*
  begin
    case (i_cfg)
      `VCD_CFG_OPEN: drive = cmd_th;
      `VCD_CFG_INT:  drive = u_in;
      `VCD_CFG_EXT:  drive = u_ex;
      `VCD_CFG_COMB: drive = u_in;
      default:       drive = 16'sh0;
    endcase
  end

  // scale so 100 % gives exactly the limit
  assign mag    = drive[15] ? (drive == `VCD_NFULL ? 16'h4000 : -drive) : drive;
  assign base_a = drive[15] ? 29'h0 : ((mag * i_lim_a) >> `VCD_FRAC);
  assign base_b = drive[15] ? ((mag * i_lim_b) >> `VCD_FRAC) : 29'h0;
  assign ol_a   = (i_cfg == `VCD_CFG_OPEN && drive > 16'sh0) ? {1'b0, i_db_a[12:0]} : 14'h0;
  assign ol_b   = (i_cfg == `VCD_CFG_OPEN && drive < 16'sh0) ? {1'b0, i_db_b[12:0]} : 14'h0;

  // triangle dither; only on an energised coil so a closed coil stays off
  assign dith_prod = i_dith_amp * phase_r[22:15];  // full width: a 13 bit product wraps at larger amplitudes
  assign dith = phase_r[23] ? $signed({2'h0, i_dith_amp}) - $signed({1'b0, dith_prod[20:7]})
                            : $signed({1'b0, dith_prod[20:7]}) - $signed({2'h0, i_dith_amp});
  assign tot_a = $signed({2'h0, base_a[13:0]}) + $signed({2'h0, ol_a}) +
                 ((base_a != 29'h0) ? {dith[14], dith} : 16'sh0);
  assign tot_b = $signed({2'h0, base_b[13:0]}) + $signed({2'h0, ol_b}) +
                 ((base_b != 29'h0) ? {dith[14], dith} : 16'sh0);

  always @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      phase_r <= 24'h0;
      o_cur_a <= 13'h0;
      o_cur_b <= 13'h0;
    end
    else
    begin
      // phase steps each clock; increment sets frequency
      phase_r <= phase_r + i_dith_inc;
      o_cur_a <= clip(tot_a, i_lim_a);
      o_cur_b <= clip(tot_b, i_lim_b);
    end
  end
endmodule // vcd_chain

// file: shared/vcd_defines.vh
`ifndef VCD_DEFINES_VH
`define VCD_DEFINES_VH
// signal width: signed q1.14 percent, 16384 = 100 %
`define VCD_W          16
`define VCD_FULL       16'sh4000
`define VCD_NFULL      -16'sh4000
// configuration select codes
`define VCD_CFG_OPEN   2'h0
`define VCD_CFG_INT    2'h1
`define VCD_CFG_EXT    2'h2
`define VCD_CFG_COMB   2'h3
// external sensor type codes
`define VCD_SENS_V10   2'h0
`define VCD_SENS_I20   2'h1
`define VCD_SENS_I420  2'h2
// feedback polarity codes
`define VCD_POL_OFF    2'h0
`define VCD_POL_POS    2'h1
`define VCD_POL_NEG    2'h2
// raw sensor adc: 12 bit, 4 mA point of 20 mA span
`define VCD_ADC_FULL   12'hfff
`define VCD_ADC_4MA    12'h333
// fraction bits of gains
`define VCD_FRAC       14
// last count of the control sample period, 4000 clocks less one (40 MHz / 10 kHz)
`define VCD_SAMPLE_CYC 12'hf9f
// dither phase accumulator width
`define VCD_PH_W       24
// current outputs in ma, 13 bits (0..8191)
`define VCD_MA_W       13
`endif

// file: testbench/vcd_chain_sva.sv
`timescale 1ns/1ps
module vcd_chain_chk
(
  // watched ports
  input wire               i_clk,
  input wire               i_rstn,
  input wire [1:0]         i_cfg,
  input wire [15:0]        i_threshold,
  input wire [15:0]        i_db_a,
  input wire [12:0]        i_lim_a,
  input wire [12:0]        i_lim_b,
  input wire [12:0]        i_dith_amp,
  input wire [1:0]         i_sens_type,
  input wire               i_sens_type_set,
  input wire signed [15:0] i_cmd,
  input wire [12:0]        o_cur_a,
  input wire [12:0]        o_cur_b,
  input wire [1:0]         o_sens_type,
  input wire               o_tick
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // cycles since last tick; first tick after reset has no reference
  logic [11:0] gap_r;
  logic        seen_r;
  always @(posedge i_clk or negedge i_rstn)
    if (!i_rstn)
    begin
      gap_r  <= 12'h000;
      seen_r <= 1'b0;
    end
    else if (o_tick)
    begin
      gap_r  <= 12'h000;
      seen_r <= 1'b1;
    end
    else
      gap_r <= gap_r + 12'h001;
  sequence type_set_s;
    i_sens_type_set;
  endsequence
  AST_LIM_A: assert property (o_cur_a <= $past(i_lim_a)) else $error("coil a above limit");
  AST_LIM_B: assert property (o_cur_b <= $past(i_lim_b)) else $error("coil b above limit");
  AST_ONE_COIL: assert property (!(o_cur_a != 13'h0 && o_cur_b != 13'h0)) else $error("both coils on");
  AST_FULL_A: assert property (i_cfg == 2'h0 && i_cmd == 16'sh4000 && i_db_a == 16'h0 && i_dith_amp == 13'h0
    |=> o_cur_a == $past(i_lim_a)) else $error("full scale not at limit");
  AST_ZERO: assert property (i_cfg == 2'h0 && i_cmd == 16'sh0 |=> o_cur_a == 13'h0 && o_cur_b == 13'h0)
    else $error("current at zero command");
  AST_THRESH: assert property (i_cfg == 2'h0 && !i_cmd[15] && i_cmd < i_threshold
    |=> o_cur_a == 13'h0 && o_cur_b == 13'h0) else $error("command under threshold passed");
  AST_STEP: assert property (i_cfg == 2'h0 && i_cmd == 16'sh1 && i_threshold == 16'h0 && i_dith_amp == 13'h0
    && i_db_a[12:0] <= i_lim_a |=> o_cur_a == $past(i_db_a[12:0])) else $error("dead band step wrong");
  AST_TYPE_SET: assert property (type_set_s |=> o_sens_type == $past(i_sens_type))
    else $error("sensor type not latched");
  AST_TYPE_HOLD: assert property (!i_sens_type_set |=> $stable(o_sens_type)) else $error("sensor type moved");
  AST_TICK: assert property (o_tick && seen_r |-> gap_r == 12'd3999) else $error("sample period wrong");
endmodule // vcd_chain_chk

bind vcd_chain vcd_chain_chk u_chk (.i_clk, .i_rstn, .i_cfg, .i_threshold, .i_db_a, .i_lim_a, .i_lim_b,
  .i_dith_amp, .i_sens_type, .i_sens_type_set, .i_cmd, .o_cur_a, .o_cur_b, .o_sens_type, .o_tick);

// file: testbench/vcd_plant.sv
`timescale 1ns/1ps
module vcd_plant
(
  // clock and reset
  input  wire               i_clk,
  input  wire               i_rstn,
  // coil currents
  input  wire [12:0]        i_cur_a,
  input  wire [12:0]        i_cur_b,
  // sensors
  output logic signed [15:0] o_fb_int,
  output logic [11:0]        o_fb_ext_raw
);
  // spool lags the coil force; slow so the loop sees a real plant
  logic signed [15:0] pos_r;
  logic signed [15:0] tgt;
  assign tgt          = ($signed({3'b000, i_cur_a}) - $signed({3'b000, i_cur_b})) <<< 4;
  assign o_fb_int     = pos_r;
  assign o_fb_ext_raw = 12'h800 + pos_r[15:4];
  always @(posedge i_clk or negedge i_rstn)
    if (!i_rstn)
      pos_r <= 16'sh0;
    else
      pos_r <= pos_r + ((tgt - pos_r) >>> 4);
endmodule // vcd_plant

// file: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic i_clk = 1'b0, i_rstn = 1'b0, set = 1'b0;
  logic [1:0] cfg = 2'h0, st = 2'h0, pol = 2'h1, o_sens_type;
  logic [15:0] thr = 16'h0, db_a = 16'h0, db_b = 16'h0, p_in = 16'h0, t_in = 16'h0, gz = 16'h0;
  logic [12:0] lim_a = 13'd1000, lim_b = 13'd800, amp = 13'h0, o_cur_a, o_cur_b, mx, mn;
  logic [23:0] inc = 24'h000800;
  logic signed [15:0] cmd = 16'sh0, fb_int;
  logic [11:0] fb_raw;
  logic o_tick;
  int error_cnt = 0, compares = 0;
  initial forever #12.5 i_clk = ~i_clk;
  vcd_chain dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_cfg(cfg), .i_threshold(thr), .i_db_a(db_a), .i_db_b(db_b),
    .i_lim_a(lim_a), .i_lim_b(lim_b), .i_dith_amp(amp), .i_dith_inc(inc), .i_sens_type(st),
    .i_sens_type_set(set), .i_fb_pol(pol), .i_p_in(p_in), .i_i_in(gz), .i_d_in(gz), .i_t_in(t_in),
    .i_p_ex(p_in), .i_i_ex(gz), .i_d_ex(gz), .i_t_ex(t_in), .i_cmd(cmd), .i_fb_int(fb_int),
    .i_fb_ext_raw(fb_raw), .o_cur_a(o_cur_a), .o_cur_b(o_cur_b), .o_sens_type(o_sens_type), .o_tick(o_tick));
  vcd_plant u_plant (.i_clk(i_clk), .i_rstn(i_rstn), .i_cur_a(o_cur_a), .i_cur_b(o_cur_b),
    .o_fb_int(fb_int), .o_fb_ext_raw(fb_raw));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // new command at falling edge, read after the registered update lands
  task automatic step(input logic signed [15:0] c);
    @(negedge i_clk) cmd = c;
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
  endtask
  // inputs set at this negedge reach the next tick; returns once the new currents have landed
  task automatic tick_wait;
    while (!o_tick) @(negedge i_clk);
    repeat (2) @(negedge i_clk);
  endtask
  task automatic tally_and_finish;
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    #(25 * 80000);
    error_cnt++;
    tally_and_finish();
  end
  initial
  begin
    repeat (2) @(negedge i_clk);
    chk(o_cur_a, 16'h0);
    chk(o_sens_type, 16'h0);
    i_rstn = 1'b1;
    step(16'sh2000); chk(o_cur_a, 16'd500);
    chk(o_cur_b, 16'h0);
    step(16'sh4000); chk(o_cur_a, 16'd1000);
    step(-16'sh4000); chk(o_cur_b, 16'd800);
    chk(o_cur_a, 16'h0);
    $display("test basic scaling done");
    db_a = 16'd100; db_b = 16'd50;
    step(16'sh1); chk(o_cur_a, 16'd100);
    step(-16'sh1); chk(o_cur_b, 16'd50);
    step(16'sh2000); chk(o_cur_a, 16'd600);
    step(16'sh4000); chk(o_cur_a, 16'd1000);
    thr = 16'd1638;
    step(16'sh3e8); chk(o_cur_a, 16'h0);
    step(16'sh7d0); chk(o_cur_a, 16'd222);
    $display("test dead band and threshold done");
    for (int k = 0; k < 3; k++)
    begin
      @(negedge i_clk) st = k[1:0]; set = 1'b1;
      @(negedge i_clk) set = 1'b0; st = 2'h1;
      @(negedge i_clk) chk(o_sens_type, 16'(k));
    end
    $display("test sensor type done");
    thr = 16'h0; db_a = 16'h0; amp = 13'd50;
    step(16'sh2000);
    mx = o_cur_a; mn = o_cur_a;
    // one full dither period at this phase step
    repeat (8192)
    begin
      @(negedge i_clk);
      if (o_cur_a > mx) mx = o_cur_a;
      if (o_cur_a < mn) mn = o_cur_a;
    end
    chk(16'(mx - mn >= 13'd96 && mx - mn <= 13'd100), 16'h1);
    // recommended operating point; a full period at 100 hz is far too long to run, so only the bound
    amp = 13'd20; inc = 24'd42;
    mx = 13'd500; mn = 13'd500;
    repeat (2000)
    begin
      @(negedge i_clk);
      if (o_cur_a > mx) mx = o_cur_a;
      if (o_cur_a < mn) mn = o_cur_a;
    end
    chk(16'(mn >= 13'd480 && mx <= 13'd520), 16'h1);
    $display("test dither done");
    // spool at rest before the loop closes, so the first error is the bare command
    amp = 13'h0;
    step(16'sh0);
    repeat (200) @(negedge i_clk);
    cfg = 2'h1; p_in = 16'h4000; cmd = 16'sh2000;
    tick_wait; chk(o_cur_a, 16'd500);
    chk(o_cur_b, 16'h0);
    db_a = 16'h1000;
    tick_wait; chk(16'(o_cur_a >= 13'd261 && o_cur_a <= 13'd262), 16'h1);
    $display("test internal loop done");
    cfg = 2'h0; cmd = 16'sh0; pol = 2'h0; db_a = 16'h0;
    tick_wait;
    cfg = 2'h2; pol = 2'h1; cmd = 16'sh2000;
    tick_wait; chk(o_cur_a, 16'd124);
    pol = 2'h0;
    tick_wait; chk(o_cur_a, 16'd500);
    t_in = 16'h8000; cmd = 16'sh4000;
    tick_wait; chk(o_cur_a, 16'd750);
    cfg = 2'h0; cmd = 16'sh0; t_in = 16'h0; st = 2'h0; set = 1'b1;
    @(negedge i_clk) set = 1'b0;
    tick_wait;
    cfg = 2'h2; pol = 2'h2; cmd = 16'sh2000;
    tick_wait; chk(o_cur_a, 16'd1000);
    pol = 2'h0; cfg = 2'h3; cmd = 16'sh1000;
    tick_wait; chk(16'(o_cur_a >= 13'd511 && o_cur_a <= 13'd512), 16'h1);
    chk(o_cur_b, 16'h0);
    $display("test external and cascade done");
    st = 2'h2; set = 1'b1;
    @(negedge i_clk) set = 1'b0; i_rstn = 1'b0;
    @(negedge i_clk) chk(o_cur_a, 16'h0);
    chk(o_sens_type, 16'h0);
    i_rstn = 1'b1;
    repeat (2) @(negedge i_clk);
    $display("test reset done");
    tally_and_finish();
  end
endmodule // tb_top
